//--- hif_pkg.sv
// constants, types and carriers for the host cpu parallel port
// Contract
// - latch byte-order straps when reset releases
// - staging word resets to known pattern
// - little plus invariant inverts both low address bits, only bit 1 when wide
// - little non-invariant wide swaps word bytes
// - big-endian offset zero is most significant
// - little-endian offset zero is least significant
// - multi-word operands keep high word lowest
// - queue read returns oldest word, pops it
// - upper data lines used only when wide
// - asynchronous host strobes resynchronised internally
// - non-muxed access starts on later falling strobe
// - muxed address latched on latch strobe fall
// - update access extends cycle to 120 ns
// - cycle extend held for minimum access time
// - muxed address echoed until latch strobe rises
// - avail flags show which queue holds data
// - last-word flags mark final packet word
// - reading empty queue raises read error
// - nine address inputs including update line
// - update line moves staging to target
// - address picks written staging byte or half
package hif_pkg;

    // register map, byte addresses on the 8 direct address lines
    localparam logic [7:0] STAGING_OFS = 8'hF4;
    localparam logic [31:0] STAGING_RST = 32'h0F0A0500;
    localparam logic [7:0] RX_REQ_OFS = 8'hC0;
    localparam logic [7:0] RX_RSP_OFS = 8'hC4;

    // field widths
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;

    // timing
    localparam int CLK_PS = 4000;
    localparam int MIN_ACCESS_NS = 40;
    localparam int EXT_ACCESS_NS = 120;
    localparam int MIN_CYC = (MIN_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int EXT_CYC = (EXT_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 8;

    // transmit transaction codes
    typedef enum logic [3:0] {
        TC_QWRITE_REQ = 4'h0,
        TC_BWRITE_REQ = 4'h1,
        TC_WRITE_RSP = 4'h2,
        TC_QREAD_REQ = 4'h4,
        TC_BREAD_REQ = 4'h5,
        TC_QREAD_RSP = 4'h6,
        TC_BREAD_RSP = 4'h7,
        TC_LOCK_REQ = 4'h9,
        TC_ASYNC_STREAM = 4'hA,
        TC_LOCK_RSP = 4'hB
    } tcode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_HOLD = 2'b11,
        ST_DONE = 2'b10
    } hif_state_e;

    typedef struct packed {
        logic little;
        logic invariant;
        logic wide;
        logic muxed;
    } straps_s;

    typedef struct packed {
        logic [31:0] data;
        logic valid;
        logic last;
    } rxq_s;

    typedef struct packed {
        logic req_avail;
        logic rsp_avail;
        logic req_last;
        logic rsp_last;
        logic read_err;
    } qstat_s;

endpackage : hif_pkg

//--- hif_port.sv
// host cpu parallel port: straps, byte lanes, staging word, receive queue reads
`timescale 1ns/1ps
module hif_port (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // configuration straps
    input wire logic little_order_strap_i,
    input wire logic invariant_strap_i,
    input wire logic wide_bus_strap_i,
    input wire logic muxed_bus_strap_i,
    // host strobes
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic addr_latch_strobe_i,
    input wire logic update_line_i,
    output logic cycle_extend_o,
    // address lines, outputs only in muxed mode
    input wire logic [7:0] addr_i,
    output logic [7:0] addr_o,
    output logic addr_oe_o,
    // low data lines, shared with address in muxed mode
    input wire logic [7:0] muxed_addr_data_i,
    output logic [7:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe_o,
    // upper data lines
    input wire logic [7:0] data_hi_i,
    output logic [7:0] data_hi_o,
    output logic data_hi_oe_o,
    // internal register target
    output logic [7:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [31:0] reg_rdata_i,
    // receive queues
    input wire hif_pkg::rxq_s req_q_i,
    input wire hif_pkg::rxq_s rsp_q_i,
    output logic req_pop_o,
    output logic rsp_pop_o,
    // status
    input wire logic queue_err_clr_i,
    output hif_pkg::qstat_s async_event_ack_o,
    output hif_pkg::straps_s straps_o
);

    // five strobes, four straps, then three byte-wide pin groups
    localparam int SYN_W = 9 + 3 * hif_pkg::ADDR_W;
    localparam logic [hif_pkg::CNT_W-1:0] MIN_CNT = hif_pkg::CNT_W'(hif_pkg::MIN_CYC);
    localparam logic [hif_pkg::CNT_W-1:0] EXT_CNT = hif_pkg::CNT_W'(hif_pkg::EXT_CYC);

    typedef struct packed {
        hif_pkg::hif_state_e st;
        hif_pkg::straps_s cfg;
        logic cfg_done;
        logic [31:0] stage;
        logic [7:0] lat_addr;
        logic [7:0] addr;
        logic upd;
        logic rd;
        logic fetch;
        logic [hif_pkg::CNT_W-1:0] cnt;
        logic ext;
        logic act_q;
        logic ale_q;
        logic [7:0] echo;
        logic a_oe;
        logic [7:0] d_lo;
        logic [7:0] d_hi;
        logic lo_oe;
        logic hi_oe;
        logic [7:0] reg_addr;
        logic [31:0] reg_wdata;
        logic reg_wr;
        logic reg_rd;
        logic req_pop;
        logic rsp_pop;
        hif_pkg::qstat_s stat;
    } hif_s;

    hif_s r;
    hif_s next_r;

    logic [SYN_W-1:0] syn;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic upd;
    hif_pkg::straps_s straps;
    logic [7:0] a_s;
    logic [7:0] ad_s;
    logic [7:0] dh_s;

    // every pin crosses two flops before use
    hif_sync #(
        .W(SYN_W)
    ) hif_sync_i (
        .mclk_i(mclk_i),
        .d_i({chip_select_n_i, read_strobe_n_i, write_strobe_n_i, addr_latch_strobe_i,
              update_line_i, little_order_strap_i, invariant_strap_i, wide_bus_strap_i,
              muxed_bus_strap_i, addr_i, muxed_addr_data_i, data_hi_i}),
        .q_o(syn)
    );

    assign {cs_n, rd_n, wr_n, ale, upd} = syn[SYN_W-1 -: 5];
    assign straps = syn[SYN_W-6 -: 4];
    assign a_s = syn[23:16];
    assign ad_s = syn[15:8];
    assign dh_s = syn[7:0];

    // byte position from the lsb end of the word for a host address
    function automatic logic [1:0] lane_pos(input hif_pkg::straps_s c, input logic [1:0] a);
        logic [1:0] ia;
        ia = a;
        if (c.little && c.invariant) begin
            ia = c.wide ? {~a[1], a[0]} : ~a;
        end
        if (c.little && !c.invariant) begin
            lane_pos = ia;
        end else begin
            lane_pos = 2'(2'b11 - ia);
        end
    endfunction : lane_pos

    function automatic logic [31:0] write_lane(input hif_pkg::straps_s c, input logic [1:0] a,
                                               input logic [31:0] w, input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [1:0] p;
        logic [31:0] v;
        p = lane_pos(c, a);
        v = w;
        if (c.wide) begin
            if (c.little && !c.invariant) begin
                v[{p[1], 4'h0} +: hif_pkg::HALF_W] = {lo, hi};
            end else begin
                v[{p[1], 4'h0} +: hif_pkg::HALF_W] = {hi, lo};
            end
        end else begin
            v[{p, 3'b000} +: hif_pkg::BYTE_W] = lo;
        end
        write_lane = v;
    endfunction : write_lane

    function automatic logic [15:0] read_lane(input hif_pkg::straps_s c, input logic [1:0] a,
                                              input logic [31:0] w);
        logic [1:0] p;
        logic [15:0] h;
        p = lane_pos(c, a);
        h = w[{p[1], 4'h0} +: hif_pkg::HALF_W];
        if (!c.wide) begin
            read_lane = {8'h00, w[{p, 3'b000} +: hif_pkg::BYTE_W]};
        end else if (c.little && !c.invariant) begin
            read_lane = {h[7:0], h[15:8]};
        end else begin
            read_lane = h;
        end
    endfunction : read_lane

    logic act;
    logic start;
    logic ale_fall;
    logic is_req;
    logic is_rsp;
    logic is_stage;
    logic [7:0] acc_addr;
    logic busy;

    always_comb begin
        act = !cs_n && (!rd_n || !wr_n);
        // later of select and strobe falling opens the cycle
        start = r.cfg_done && act && !r.act_q;
        ale_fall = r.ale_q && !ale;
        acc_addr = r.cfg.muxed ? r.lat_addr : a_s;
        is_req = acc_addr[7:2] == hif_pkg::RX_REQ_OFS[7:2];
        is_rsp = acc_addr[7:2] == hif_pkg::RX_RSP_OFS[7:2];
        is_stage = acc_addr[7:2] == hif_pkg::STAGING_OFS[7:2];
        busy = r.st == hif_pkg::ST_XFER || r.st == hif_pkg::ST_HOLD;
    end

    always_comb begin
        next_r = r;
        next_r.act_q = act;
        next_r.ale_q = ale;
        next_r.reg_wr = 1'b0;
        next_r.reg_rd = 1'b0;
        next_r.req_pop = 1'b0;
        next_r.rsp_pop = 1'b0;
        next_r.fetch = r.reg_rd;

        // straps are taken once, at the first edge after reset lets go
        if (!r.cfg_done) begin
            next_r.cfg = straps;
            next_r.cfg_done = 1'b1;
        end
        next_r.a_oe = r.cfg_done && r.cfg.muxed;

        if (r.cfg.muxed) begin
            // echo follows the bus while latch is high, freezes after
            if (ale) begin
                next_r.echo = ad_s;
            end
            if (ale_fall) begin
                next_r.lat_addr = ad_s;
            end
        end

        next_r.stat.req_avail = req_q_i.valid;
        next_r.stat.rsp_avail = rsp_q_i.valid;
        next_r.stat.req_last = req_q_i.valid && req_q_i.last;
        next_r.stat.rsp_last = rsp_q_i.valid && rsp_q_i.last;
        if (queue_err_clr_i) begin
            next_r.stat.read_err = 1'b0;
        end

        // target answers one cycle after the read strobe
        if (r.fetch) begin
            next_r.stage = reg_rdata_i;
        end

        case (r.st)
            hif_pkg::ST_IDLE: begin
                if (start) begin
                    next_r.addr = acc_addr;
                    next_r.upd = upd;
                    next_r.rd = !rd_n;
                    next_r.ext = 1'b1;
                    next_r.cnt = upd ? EXT_CNT : MIN_CNT;
                    next_r.st = hif_pkg::ST_XFER;
                    if (!rd_n) begin
                        if (upd && is_req) begin
                            if (r.stat.req_avail) begin
                                next_r.stage = req_q_i.data;
                                next_r.req_pop = 1'b1;
                            end else begin
                                next_r.stat.read_err = 1'b1;
                            end
                        end else if (upd && is_rsp) begin
                            if (r.stat.rsp_avail) begin
                                next_r.stage = rsp_q_i.data;
                                next_r.rsp_pop = 1'b1;
                            end else begin
                                next_r.stat.read_err = 1'b1;
                            end
                        end else if (upd && !is_stage) begin
                            next_r.reg_addr = acc_addr;
                            next_r.reg_rd = 1'b1;
                        end
                        // plain reads only show the staging word, so a
                        // popped word survives until the host has all of it
                    end else begin
                        next_r.stage = write_lane(r.cfg, acc_addr[1:0], r.stage,
                                                  ad_s, r.cfg.wide ? dh_s : 8'h00);
                        if (upd && !is_stage && !is_req && !is_rsp) begin
                            // whole word moves to the target in one strobe
                            next_r.reg_addr = acc_addr;
                            next_r.reg_wdata = write_lane(r.cfg, acc_addr[1:0], r.stage,
                                                          ad_s, r.cfg.wide ? dh_s : 8'h00);
                            next_r.reg_wr = 1'b1;
                        end
                    end
                end
            end
            hif_pkg::ST_XFER: begin
                next_r.cnt = hif_pkg::CNT_W'(r.cnt - 1'b1);
                if (r.cnt <= 8'h01) begin
                    next_r.ext = 1'b0;
                    next_r.st = hif_pkg::ST_HOLD;
                end
            end
            hif_pkg::ST_HOLD: begin
                if (!act) begin
                    next_r.st = hif_pkg::ST_DONE;
                end
            end
            hif_pkg::ST_DONE: begin
                next_r.st = hif_pkg::ST_IDLE;
            end
            default: begin
                next_r.st = hif_pkg::ST_IDLE;
                next_r.ext = 1'b0;
            end
        endcase

        // read data tracks the staging word while the cycle is open
        if (r.rd && busy) begin
            {next_r.d_hi, next_r.d_lo} = read_lane(r.cfg, r.addr[1:0], next_r.stage);
        end
        // release the bus as soon as the host lets go of the strobes
        next_r.lo_oe = act && r.rd && busy;
        next_r.hi_oe = act && r.rd && r.cfg.wide && busy;
        // idle must not clear it: the start decision above sets it there
        if (r.st == hif_pkg::ST_DONE) begin
            next_r.rd = 1'b0;
        end

        // a new error wins over a clear in the same cycle
        if (queue_err_clr_i && !(next_r.stat.read_err && !r.stat.read_err)) begin
            next_r.stat.read_err = 1'b0;
        end
        next_r.stat.read_err = next_r.stat.read_err | (start && !rd_n && upd &&
            ((is_req && !r.stat.req_avail) || (is_rsp && !r.stat.rsp_avail)));
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.st <= hif_pkg::ST_IDLE;
            r.stage <= hif_pkg::STAGING_RST;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from state flops
    assign cycle_extend_o = r.ext;
    assign addr_o = r.echo;
    assign addr_oe_o = r.a_oe;
    assign muxed_addr_data_o = r.d_lo;
    assign muxed_addr_data_oe_o = r.lo_oe;
    assign data_hi_o = r.d_hi;
    assign data_hi_oe_o = r.hi_oe;
    assign reg_addr_o = r.reg_addr;
    assign reg_wdata_o = r.reg_wdata;
    assign reg_wr_o = r.reg_wr;
    assign reg_rd_o = r.reg_rd;
    assign req_pop_o = r.req_pop;
    assign rsp_pop_o = r.rsp_pop;
    assign async_event_ack_o = r.stat;
    assign straps_o = r.cfg;

endmodule : hif_port

//--- hif_port_bench.sv
// self-checking bench for the host parallel port
`timescale 1ns/1ps
module hif_port_bench;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, addr_latch_strobe_i = 1'b0;
    logic little_order_strap_i = 1'b0, invariant_strap_i = 1'b0;
    logic wide_bus_strap_i = 1'b0, muxed_bus_strap_i = 1'b0;
    logic chip_select_n_i = 1'b1, read_strobe_n_i = 1'b1, write_strobe_n_i = 1'b1;
    logic update_line_i = 1'b0, queue_err_clr_i = 1'b0;
    logic [7:0] a_drv = 8'h00, ad_drv = 8'h00, addr_i, addr_o, reg_addr_o;
    logic [7:0] muxed_addr_data_i, muxed_addr_data_o, data_hi_i, data_hi_o;
    logic [31:0] reg_wdata_o, reg_rdata_i;
    logic cycle_extend_o, addr_oe_o, muxed_addr_data_oe_o, data_hi_oe_o;
    logic reg_wr_o, reg_rd_o, req_pop_o, rsp_pop_o;
    hif_pkg::rxq_s req_q_i, rsp_q_i;
    hif_pkg::qstat_s async_event_ack_o;
    hif_pkg::straps_s straps_o;
    int err_total = 0, n_checks = 0, cyc = 0;
    logic [15:0] r;
    // the port wins the shared lines whenever it enables them
    assign addr_i = addr_oe_o ? addr_o : a_drv;
    assign muxed_addr_data_i = muxed_addr_data_oe_o ? muxed_addr_data_o : ad_drv;
    assign data_hi_i = data_hi_oe_o ? data_hi_o : 8'h00;
    hif_port hif_port_i (.mclk_i, .sys_rst_i, .little_order_strap_i, .invariant_strap_i,
        .wide_bus_strap_i, .muxed_bus_strap_i, .chip_select_n_i, .read_strobe_n_i,
        .write_strobe_n_i, .addr_latch_strobe_i, .update_line_i, .cycle_extend_o, .addr_i,
        .addr_o, .addr_oe_o, .muxed_addr_data_i, .muxed_addr_data_o, .muxed_addr_data_oe_o,
        .data_hi_i, .data_hi_o, .data_hi_oe_o, .reg_addr_o, .reg_wdata_o, .reg_wr_o,
        .reg_rd_o, .reg_rdata_i, .req_q_i, .rsp_q_i, .req_pop_o, .rsp_pop_o,
        .queue_err_clr_i, .async_event_ack_o, .straps_o);
    hif_target_model hif_target_model_i (.mclk_i, .reg_rd_i(reg_rd_o), .reg_wr_i(reg_wr_o),
        .reg_addr_i(reg_addr_o), .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i),
        .req_pop_i(req_pop_o), .rsp_pop_i(rsp_pop_o), .req_q_o(req_q_i), .rsp_q_o(rsp_q_i));
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 15000) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // pins flip after release so a strap that is not held shows up
    task automatic rst(input hif_pkg::straps_s s);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        {little_order_strap_i, invariant_strap_i, wide_bus_strap_i, muxed_bus_strap_i} <= s;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        {little_order_strap_i, invariant_strap_i, wide_bus_strap_i, muxed_bus_strap_i} <= ~s;
        repeat (4) @(posedge mclk_i);
        chk("straps", 32'(straps_o), 32'(s));
    endtask : rst
    task automatic acc(input logic wr, input logic upd, input logic [7:0] a,
        input logic [7:0] wd);
        int n;
        int m;
        n = 0;
        m = 0;
        @(posedge mclk_i);
        a_drv <= a;
        ad_drv <= a;
        addr_latch_strobe_i <= straps_o.muxed;
        repeat (3) @(posedge mclk_i);
        addr_latch_strobe_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ad_drv <= wd;
        update_line_i <= upd;
        chip_select_n_i <= 1'b0;
        read_strobe_n_i <= wr;
        write_strobe_n_i <= !wr;
        while (cycle_extend_o !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        while (cycle_extend_o === 1'b1 && m < 60) begin
            @(negedge mclk_i);
            m++;
        end
        chk("wait_cycles", 32'(m), upd ? hif_pkg::EXT_CYC : hif_pkg::MIN_CYC);
        r = {data_hi_o, muxed_addr_data_o};
        @(posedge mclk_i);
        chip_select_n_i <= 1'b1;
        read_strobe_n_i <= 1'b1;
        write_strobe_n_i <= 1'b1;
        update_line_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask : acc
    // whole word fetched before the next update read
    task automatic qword(input logic [7:0] a, input logic [31:0] w, input logic upd);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, upd && i == 0, a + 8'(i), 8'h00);
            chk("byte", 32'(r[7:0]), 32'(w[31 - 8 * i -: 8]));
        end
    endtask : qword
    task automatic t_write();
        acc(1'b1, 1'b0, 8'hF5, 8'h5A);
        acc(1'b1, 1'b1, 8'h13, 8'h33);
        chk("target", hif_target_model_i.wr_word, 32'h0F5A0533);
        // target model answers a read with its address in every byte
        acc(1'b0, 1'b1, 8'h23, 8'h00);
        chk("target_rd", 32'(r[7:0]), 32'h00000023);
    endtask : t_write
    task automatic t_queue();
        hif_target_model_i.push(1'b0, {24'h0, hif_pkg::TC_QREAD_REQ, 4'h0}, 1'b0);
        hif_target_model_i.push(1'b0, 32'h55667788, 1'b1);
        hif_target_model_i.push(1'b1, {24'h0, hif_pkg::TC_LOCK_RSP, 4'h0}, 1'b1);
        repeat (3) @(negedge mclk_i);
        chk("flags", 32'(async_event_ack_o), 32'h1A);
        qword(hif_pkg::RX_REQ_OFS, 32'h00000040, 1'b1);
        chk("flags", 32'(async_event_ack_o), 32'h1E);
        qword(hif_pkg::RX_REQ_OFS, 32'h55667788, 1'b1);
        qword(hif_pkg::RX_RSP_OFS, 32'h000000B0, 1'b1);
        chk("flags", 32'(async_event_ack_o), 32'h00);
        acc(1'b0, 1'b1, hif_pkg::RX_REQ_OFS, 8'h00);
        chk("q_err", 32'(async_event_ack_o), 32'h01);
        @(posedge mclk_i);
        queue_err_clr_i <= 1'b1;
        @(posedge mclk_i);
        queue_err_clr_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("q_err", 32'(async_event_ack_o), 32'h00);
    endtask : t_queue
    task automatic t_swap();
        rst(4'b1010);
        acc(1'b0, 1'b0, 8'hF4, 8'h00);
        chk("low_half", 32'(r), 32'h00000005);
        acc(1'b0, 1'b0, 8'hF6, 8'h00);
        chk("high_half", 32'(r), 32'h00000A0F);
    endtask : t_swap
    task automatic t_mux();
        rst(4'b1101);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b0, 8'hF4 + 8'(i), 8'h00);
            chk("inv_byte", 32'(r[7:0]), 32'(hif_pkg::STAGING_RST[8 * i +: 8]));
            chk("echo", 32'(addr_o), 32'(8'hF4 + 8'(i)));
        end
        acc(1'b1, 1'b0, 8'hF4, 8'hC3);
        acc(1'b0, 1'b0, 8'hF4, 8'h00);
        chk("mux_wr", 32'(r[7:0]), 32'h000000C3);
    endtask : t_mux
    initial begin
        rst(4'b0000);
        qword(hif_pkg::STAGING_OFS, hif_pkg::STAGING_RST, 1'b0);
        t_write();
        t_queue();
        t_swap();
        t_mux();
        give_verdict();
    end
endmodule : hif_port_bench
bind hif_port hif_port_checker hif_port_checker_i (.mclk_i, .sys_rst_i, .chip_select_n_i,
    .read_strobe_n_i, .write_strobe_n_i, .update_line_i, .queue_err_clr_i, .cycle_extend_o,
    .data_hi_oe_o, .reg_wr_o, .req_pop_o, .rsp_pop_o, .req_q_i, .rsp_q_i,
    .async_event_ack_o, .straps_o);

//--- hif_port_checker.sv
// concurrent checks on the host port pins
`timescale 1ns/1ps
module hif_port_checker (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // host side
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic update_line_i,
    input wire logic queue_err_clr_i,
    input wire logic cycle_extend_o,
    input wire logic data_hi_oe_o,
    input wire logic reg_wr_o,
    input wire logic req_pop_o,
    input wire logic rsp_pop_o,
    input wire hif_pkg::rxq_s req_q_i,
    input wire hif_pkg::rxq_s rsp_q_i,
    input wire hif_pkg::qstat_s async_event_ack_o,
    input wire hif_pkg::straps_s straps_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [7:0] ext_n;
    logic [1:0] up_n;
    // straps settle at the first edge after release; the check starts from the fourth
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_n <= 8'h00;
            up_n <= 2'h0;
        end else begin
            ext_n <= cycle_extend_o ? ext_n + 8'h01 : 8'h00;
            up_n <= (up_n == 2'h3) ? up_n : up_n + 2'h1;
        end
    end
    AST_EXT_LEN: assert property ($fell(cycle_extend_o) |->
        ext_n == (update_line_i ? 8'(hif_pkg::EXT_CYC) : 8'(hif_pkg::MIN_CYC)))
        else $error("wait length wrong");
    AST_SYNC: assert property ($rose(cycle_extend_o) |->
        !$past(chip_select_n_i, 2) && !chip_select_n_i)
        else $error("wait raised before strobe resync");
    // enable lingers three edges after the pin lets go, through the resync
    AST_HI_LANE: assert property (data_hi_oe_o |->
        straps_o.wide && !$past(read_strobe_n_i, 3))
        else $error("upper lane driven");
    AST_STRAPS: assert property (up_n == 2'h3 |-> $stable(straps_o))
        else $error("straps changed");
    AST_POP: assert property (req_pop_o || rsp_pop_o |->
        update_line_i && !read_strobe_n_i && !(req_pop_o && rsp_pop_o))
        else $error("bad pop");
    AST_WR: assert property (reg_wr_o |-> update_line_i && !write_strobe_n_i && cycle_extend_o)
        else $error("bad target write");
    AST_AVAIL: assert property (async_event_ack_o[4:1] == {$past(req_q_i.valid),
        $past(rsp_q_i.valid), $past(req_q_i.last), $past(rsp_q_i.last)})
        else $error("queue flags wrong");
    AST_ERR: assert property ($past(async_event_ack_o.read_err) && !$past(queue_err_clr_i)
        |-> async_event_ack_o.read_err)
        else $error("read error lost");
    cover property ($fell(cycle_extend_o) && ext_n == 8'(hif_pkg::EXT_CYC));
    cover property (req_pop_o);
    cover property ($rose(async_event_ack_o.read_err));
endmodule : hif_port_checker

//--- hif_sync.sv
// two-stage level synchroniser for host pins
`timescale 1ns/1ps
module hif_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic mclk_i,
    // pins
    input wire logic [W-1:0] d_i,
    // synchronised
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_s;

    sync_s r;
    sync_s next_r;

    // no reset: straps must be visible at the first edge after release
    always_comb begin
        next_r.meta = d_i;
        next_r.sync = r.meta;
    end

    always_ff @(posedge mclk_i) begin
        r <= next_r;
    end

    assign q_o = r.sync;

endmodule : hif_sync

//--- hif_target_model.sv
// receive queue heads and register target behind the port
`timescale 1ns/1ps
module hif_target_model (
    // clock
    input wire logic mclk_i,
    // register target
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // receive queues
    input wire logic req_pop_i,
    input wire logic rsp_pop_i,
    output hif_pkg::rxq_s req_q_o,
    output hif_pkg::rxq_s rsp_q_o
);
    logic [32:0] rq[$];
    logic [32:0] sq[$];
    logic [31:0] wr_word = 32'h00000000;
    task automatic push(input logic rsp, input logic [31:0] d, input logic last);
        if (rsp) begin
            sq.push_back({last, d});
        end else begin
            rq.push_back({last, d});
        end
    endtask : push
    always @(posedge mclk_i) begin
        // valid only the cycle after the pulse, junk otherwise
        reg_rdata_o <= reg_rd_i ? {4{reg_addr_i}} : {4{~reg_addr_i}};
        if (reg_wr_i) begin
            wr_word <= reg_wdata_i;
        end
        if (req_pop_i && rq.size() > 0) begin
            void'(rq.pop_front());
        end
        if (rsp_pop_i && sq.size() > 0) begin
            void'(sq.pop_front());
        end
        req_q_o.valid <= rq.size() > 0;
        req_q_o.last <= rq.size() > 0 && rq[0][32];
        req_q_o.data <= rq.size() > 0 ? rq[0][31:0] : 32'hA5A5A5A5;
        rsp_q_o.valid <= sq.size() > 0;
        rsp_q_o.last <= sq.size() > 0 && sq[0][32];
        rsp_q_o.data <= sq.size() > 0 ? sq[0][31:0] : 32'h5A5A5A5A;
    end
endmodule : hif_target_model
